/* inc/bcht_pkg.sv */
package bcht_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration offsets (byte addresses, dword aligned)
  localparam logic [7:0]  OFS_IO_UPPER     = 8'h30;
  localparam logic [7:0]  OFS_CAP_PTR      = 8'h34;
  localparam logic [7:0]  OFS_INT_BRIDGE   = 8'h3c;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions inside the dwords
  localparam int          BASE_LSB         = 0;
  localparam int          LIMIT_LSB        = 16;
  localparam int          LINE_LSB         = 0;
  localparam int          PIN_LSB          = 8;
  localparam int          PAR_EN_BIT       = 16;
  localparam int          SERR_EN_BIT      = 17;
  localparam int          ISA_EN_BIT       = 18;

  ////////////////////////////////////////////////////////////////////////////////
  // Fixed and reset values
  localparam logic [15:0] IO_UPPER_RST     = 16'h0000;
  localparam logic [7:0]  CAP_LIST_PTR     = 8'hdc;
  localparam logic [7:0]  INT_PIN_NONE     = 8'h00;
  localparam logic [7:0]  INT_LINE_RST     = 8'h00;
  localparam logic        CTRL_BIT_RST     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // I/O decode constants
  localparam logic [15:0] ISA_SPACE_TOP    = 16'h0000;   // Upper address half of first 64KB
  localparam logic [1:0]  ISA_LOW_256      = 2'b00;      // Addr [9:8] of first 256 bytes of 1KB
  localparam logic [11:0] IO_GRAN_ZERO     = 12'h000;
  localparam logic [11:0] IO_GRAN_ONES     = 12'hfff;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bcht_cfg_req_s;

  typedef struct packed {
    logic        valid;
    logic        upstream;
    logic [31:0] addr;
  } bcht_io_req_s;

  typedef struct packed {
    logic        in_range;
    logic        isa_alias;
    logic        take;
  } bcht_io_dec_s;

endpackage

/* hdl/bcht_io_decode.sv */
`timescale 1ns/100ps
module bcht_io_decode (
  input  wire logic [15:0]          base_upper,  // Base address [31:16]
  input  wire logic [15:0]          limit_upper, // Limit address [31:16]
  input  wire logic [3:0]           base_low,    // Base address [15:12]
  input  wire logic [3:0]           limit_low,   // Limit address [15:12]
  input  wire logic                 isa_en,      // ISA alias blocking
  input  wire bcht_pkg::bcht_io_req_s req,       // I/O request
  output      bcht_pkg::bcht_io_dec_s dec        // Decode result
);

  logic [31:0] base_addr;
  logic [31:0] limit_addr;

  // Full window from upper halves and 4KB granular lower nibbles
  assign base_addr  = {base_upper, base_low, bcht_pkg::IO_GRAN_ZERO};
  assign limit_addr = {limit_upper, limit_low, bcht_pkg::IO_GRAN_ONES};

  // Range and alias tests; limit below base gives an empty window
  always_comb begin
    dec.in_range  = (req.addr >= base_addr) && (req.addr <= limit_addr);
    dec.isa_alias = isa_en && (req.addr[31:16] == bcht_pkg::ISA_SPACE_TOP)
                    && (req.addr[9:8] != bcht_pkg::ISA_LOW_256);
    if (req.upstream) begin
      // Secondary side claims what lies outside the window, plus, with isa_en set, any address whose [9:8] is not 00, at any height
      dec.take = !dec.in_range || (isa_en && req.addr[9:8] != bcht_pkg::ISA_LOW_256);
    end else begin
      dec.take = dec.in_range && !dec.isa_alias;
    end
  end

endmodule // bcht_io_decode

/* hdl/bcht_regs.sv */
`timescale 1ns/100ps
module bcht_regs (
  input  wire logic                   clk,                      // PCI clock
  input  wire logic                   resetn,                   // Bridge reset, sync, active low
  input  wire bcht_pkg::bcht_cfg_req_s cfg_req,                 // Primary configuration cycle
  output      logic [31:0]            cfg_rdata,                // Read data, one cycle after rd
  output      logic                   cfg_rvalid,               // Read data valid pulse
  input  wire logic [3:0]             io_base_low,              // Base [15:12] from lower header
  input  wire logic [3:0]             io_limit_low,             // Limit [15:12] from lower header
  input  wire bcht_pkg::bcht_io_req_s io_req,                   // I/O transaction to decode
  output      logic                   io_fwd_valid,             // Decode answer valid pulse
  output      logic                   io_fwd_take,              // Forward the transaction
  input  wire logic                   sec_addr_parity_err,      // Secondary address parity error
  input  wire logic                   sec_data_parity_err,      // Secondary data parity error
  output      logic                   sec_parity_report,        // Parity error reported pulse
  input  wire logic                   secondary_system_error_n, // Secondary system error, low
  output      logic                   primary_system_error_n    // Forwarded system error, low
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] io_base_upper_half;
  logic [15:0] io_limit_upper_half;
  logic [7:0]  interrupt_routing_line;
  logic        par_resp_en;
  logic        serr_fwd_en;
  logic        isa_en;
  logic [15:0] next_io_base_upper_half;
  logic [15:0] next_io_limit_upper_half;
  logic [7:0]  next_interrupt_routing_line;
  logic        next_par_resp_en;
  logic        next_serr_fwd_en;
  logic        next_isa_en;
  logic [31:0] next_cfg_rdata;
  logic        next_cfg_rvalid;
  logic        next_io_fwd_valid;
  logic        next_io_fwd_take;
  logic        next_sec_parity_report;
  logic        next_primary_system_error_n;
  logic        hit_io_upper;
  logic        hit_cap_ptr;
  logic        hit_int_bridge;
  bcht_pkg::bcht_io_dec_s io_dec;

  // Dword decode; low two address bits are byte lane, not address
  assign hit_io_upper   = (cfg_req.addr[7:2] == bcht_pkg::OFS_IO_UPPER[7:2]);
  assign hit_cap_ptr    = (cfg_req.addr[7:2] == bcht_pkg::OFS_CAP_PTR[7:2]);
  assign hit_int_bridge = (cfg_req.addr[7:2] == bcht_pkg::OFS_INT_BRIDGE[7:2]);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration writes, each byte lane on its own enable
  always_comb begin
    next_io_base_upper_half     = io_base_upper_half;
    next_io_limit_upper_half    = io_limit_upper_half;
    next_interrupt_routing_line = interrupt_routing_line;
    next_par_resp_en            = par_resp_en;
    next_serr_fwd_en            = serr_fwd_en;
    next_isa_en                 = isa_en;
    if (cfg_req.wr && hit_io_upper) begin
      if (cfg_req.be[0]) begin
        next_io_base_upper_half[7:0]   = cfg_req.wdata[bcht_pkg::BASE_LSB +: 8];
      end
      if (cfg_req.be[1]) begin
        next_io_base_upper_half[15:8]  = cfg_req.wdata[bcht_pkg::BASE_LSB+8 +: 8];
      end
      if (cfg_req.be[2]) begin
        next_io_limit_upper_half[7:0]  = cfg_req.wdata[bcht_pkg::LIMIT_LSB +: 8];
      end
      if (cfg_req.be[3]) begin
        next_io_limit_upper_half[15:8] = cfg_req.wdata[bcht_pkg::LIMIT_LSB+8 +: 8];
      end
    end
    if (cfg_req.wr && hit_int_bridge) begin
      if (cfg_req.be[0]) begin
        next_interrupt_routing_line = cfg_req.wdata[bcht_pkg::LINE_LSB +: 8];
      end
      // Lane 1 is the pin byte: no storage behind it
      if (cfg_req.be[2]) begin
        next_par_resp_en = cfg_req.wdata[bcht_pkg::PAR_EN_BIT];
        next_serr_fwd_en = cfg_req.wdata[bcht_pkg::SERR_EN_BIT];
        next_isa_en      = cfg_req.wdata[bcht_pkg::ISA_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      io_base_upper_half     <= bcht_pkg::IO_UPPER_RST;
      io_limit_upper_half    <= bcht_pkg::IO_UPPER_RST;
      interrupt_routing_line <= bcht_pkg::INT_LINE_RST;
      par_resp_en            <= bcht_pkg::CTRL_BIT_RST;
      serr_fwd_en            <= bcht_pkg::CTRL_BIT_RST;
      isa_en                 <= bcht_pkg::CTRL_BIT_RST;
    end else begin
      io_base_upper_half     <= next_io_base_upper_half;
      io_limit_upper_half    <= next_io_limit_upper_half;
      interrupt_routing_line <= next_interrupt_routing_line;
      par_resp_en            <= next_par_resp_en;
      serr_fwd_en            <= next_serr_fwd_en;
      isa_en                 <= next_isa_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration reads; offsets outside this block read zero
  always_comb begin
    next_cfg_rdata  = 32'h0000_0000;
    next_cfg_rvalid = cfg_req.rd;
    if (cfg_req.rd) begin
      if (hit_io_upper) begin
        next_cfg_rdata = {io_limit_upper_half, io_base_upper_half};
      end else if (hit_cap_ptr) begin
        next_cfg_rdata[7:0] = bcht_pkg::CAP_LIST_PTR;
      end else if (hit_int_bridge) begin
        next_cfg_rdata[bcht_pkg::LINE_LSB +: 8] = interrupt_routing_line;
        next_cfg_rdata[bcht_pkg::PIN_LSB +: 8]  = bcht_pkg::INT_PIN_NONE;
        next_cfg_rdata[bcht_pkg::PAR_EN_BIT]    = par_resp_en;
        next_cfg_rdata[bcht_pkg::SERR_EN_BIT]   = serr_fwd_en;
        next_cfg_rdata[bcht_pkg::ISA_EN_BIT]    = isa_en;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // I/O window decode
  bcht_io_decode u_io_decode (
    .base_upper  (io_base_upper_half),
    .limit_upper (io_limit_upper_half),
    .base_low    (io_base_low),
    .limit_low   (io_limit_low),
    .isa_en      (isa_en),
    .req         (io_req),
    .dec         (io_dec)
  );

  // Answer registered so decode timing stays off the outputs
  always_comb begin
    next_io_fwd_valid = io_req.valid;
    next_io_fwd_take  = io_req.valid && io_dec.take;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Secondary error handling
  always_comb begin
    next_sec_parity_report      = par_resp_en && (sec_addr_parity_err || sec_data_parity_err);
    next_primary_system_error_n = !(serr_fwd_en && !secondary_system_error_n);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_rdata              <= 32'h0000_0000;
      cfg_rvalid             <= 1'b0;
      io_fwd_valid           <= 1'b0;
      io_fwd_take            <= 1'b0;
      sec_parity_report      <= 1'b0;
      primary_system_error_n <= 1'b1;
    end else begin
      cfg_rdata              <= next_cfg_rdata;
      cfg_rvalid             <= next_cfg_rvalid;
      io_fwd_valid           <= next_io_fwd_valid;
      io_fwd_take            <= next_io_fwd_take;
      sec_parity_report      <= next_sec_parity_report;
      primary_system_error_n <= next_primary_system_error_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_base_write: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req.wr && hit_io_upper && cfg_req.be[1:0] == 2'b11
    |=> io_base_upper_half == $past(cfg_req.wdata[15:0]))
    else $error("base upper half not written");

  // Read two edges after the write must return the written limit, not just the stored one
  a_limit_write: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req.wr && hit_io_upper && cfg_req.be[3:2] == 2'b11 ##1 !cfg_req.wr ##1 (cfg_req.rd && hit_io_upper)
    |=> cfg_rdata[31:16] == $past(cfg_req.wdata[31:16], 3))
    else $error("limit upper half not returned");

  a_lane_hold: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req.wr && hit_io_upper && cfg_req.be[3:2] == 2'b00
    |=> $stable(io_limit_upper_half))
    else $error("disabled lane changed limit");

  a_cap_pointer: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req.rd && hit_cap_ptr |=> cfg_rvalid && cfg_rdata == 32'h0000_00dc)
    else $error("capability pointer wrong");

  a_line_pin_read: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req.rd && hit_int_bridge
    |=> cfg_rdata[15:0] == {8'h00, $past(interrupt_routing_line)})
    else $error("line or pin byte wrong");

  a_parity_gate: assert property (@(posedge clk) disable iff (!resetn)
    (sec_addr_parity_err || sec_data_parity_err) |=> sec_parity_report == $past(par_resp_en))
    else $error("parity report not gated by enable");

  a_serr_forward: assert property (@(posedge clk) disable iff (!resetn)
    !secondary_system_error_n |=> primary_system_error_n == !$past(serr_fwd_en))
    else $error("system error forwarding wrong");

  a_range_forward: assert property (@(posedge clk) disable iff (!resetn)
    io_req.valid && !io_req.upstream && !isa_en && io_dec.in_range |=> io_fwd_valid && io_fwd_take)
    else $error("in range I/O not forwarded");

  a_isa_block: assert property (@(posedge clk) disable iff (!resetn)
    io_req.valid && !io_req.upstream && io_dec.in_range && io_dec.isa_alias |=> io_fwd_valid && !io_fwd_take)
    else $error("ISA alias forwarded downstream");

  a_isa_upstream: assert property (@(posedge clk) disable iff (!resetn)
    io_req.valid && io_req.upstream && isa_en && io_req.addr[9:8] != 2'b00 |=> io_fwd_take)
    else $error("ISA alias not forwarded upstream");

  c_isa_blocked: cover property (@(posedge clk) disable iff (!resetn)
    io_req.valid && !io_req.upstream && io_dec.in_range && io_dec.isa_alias);
  c_serr_passed: cover property (@(posedge clk) disable iff (!resetn) !primary_system_error_n);
  c_parity_seen: cover property (@(posedge clk) disable iff (!resetn) sec_parity_report);
  c_ctrl_write: cover property (@(posedge clk) disable iff (!resetn)
    cfg_req.wr && hit_int_bridge && cfg_req.be[2] && cfg_req.wdata[18]);

endmodule // bcht_regs

/* verification/bcht_host_model.sv */
`timescale 1ns/100ps
module bcht_host_model (
  input  wire logic                    clk,        // PCI clock
  output      bcht_pkg::bcht_cfg_req_s cfg_req,    // Configuration cycle
  input  wire logic [31:0]             cfg_rdata,  // Read data
  input  wire logic                    cfg_rvalid  // Read data valid
);
  // No strobes on an idle bus
  initial cfg_req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Write: one strobe cycle, then qualifiers inverted so stale values never match
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
    @(negedge clk);
    cfg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~b, wdata: ~d};
  endtask

  // Read: answer stands one cycle only, so it is taken at the next falling edge
  task automatic cfg_read(input logic [7:0] a, output logic v, output logic [31:0] d);
    @(negedge clk);
    cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: ~cfg_req.wdata};
    @(negedge clk);
    v = cfg_rvalid;
    d = cfg_rdata;
    cfg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: cfg_req.wdata};
  endtask
endmodule // bcht_host_model

/* verification/bcht_regs_bench.sv */
`timescale 1ns/100ps
module bcht_regs_bench;
  logic                    clk = 1'b0;
  logic                    resetn = 1'b0;
  bcht_pkg::bcht_cfg_req_s cfg_req;
  logic [31:0]             cfg_rdata;
  logic                    cfg_rvalid;
  logic [3:0]              io_base_low = 4'h1;
  logic [3:0]              io_limit_low = 4'h2;
  bcht_pkg::bcht_io_req_s  io_req = '0;
  logic                    io_fwd_valid;
  logic                    io_fwd_take;
  logic                    sec_addr_parity_err = 1'b0;
  logic                    sec_data_parity_err = 1'b0;
  logic                    sec_parity_report;
  logic                    secondary_system_error_n = 1'b1;
  logic                    primary_system_error_n;
  int                      error_cnt = 0;
  int                      compares = 0;
  logic                    rv;
  logic [31:0]             rd;

  // 100 MHz clock
  always #5 clk = ~clk;

  bcht_regs i_bcht_regs (.clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .io_base_low(io_base_low), .io_limit_low(io_limit_low), .io_req(io_req),
    .io_fwd_valid(io_fwd_valid), .io_fwd_take(io_fwd_take), .sec_addr_parity_err(sec_addr_parity_err),
    .sec_data_parity_err(sec_data_parity_err), .sec_parity_report(sec_parity_report),
    .secondary_system_error_n(secondary_system_error_n), .primary_system_error_n(primary_system_error_n));

  bcht_host_model i_bcht_host_model (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict, shared by main sequence and watchdog
  task automatic stop_test();
    $display("TB: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    i_bcht_host_model.cfg_write(a, b, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    i_bcht_host_model.cfg_read(a, rv, rd);
    chk("read valid", 32'h1, {31'h0, rv});
    chk("read data", exp, rd);
  endtask

  // Decode answer arrives one edge after the request
  task automatic io_chk(input logic up, input logic [31:0] a, input logic exp);
    @(negedge clk);
    io_req = '{valid: 1'b1, upstream: up, addr: a};
    @(negedge clk);
    io_req = '{valid: 1'b0, upstream: ~up, addr: ~a};
    chk("io valid", 32'h1, {31'h0, io_fwd_valid});
    chk("io take", {31'h0, exp}, {31'h0, io_fwd_take});
  endtask

  // Error inputs held one cycle; outputs follow one edge later
  task automatic err_chk(input logic ae, input logic de, input logic se, input logic rep, input logic pn);
    @(negedge clk);
    sec_addr_parity_err = ae;
    sec_data_parity_err = de;
    secondary_system_error_n = ~se;
    @(negedge clk);
    chk("parity report", {31'h0, rep}, {31'h0, sec_parity_report});
    chk("primary serr", {31'h0, pn}, {31'h0, primary_system_error_n});
    sec_addr_parity_err = 1'b0;
    sec_data_parity_err = 1'b0;
    secondary_system_error_n = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    rd_chk(8'h30, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_00dc);
    rd_chk(8'h3c, 32'h0000_0000);
    $display("TB: reset values done");
    wr(8'h30, 4'hf, 32'h1234_5678);
    wr(8'h30, 4'h2, 32'hffff_abff);
    rd_chk(8'h30, 32'h1234_ab78);
    wr(8'h30, 4'hc, 32'h9abc_0000);
    rd_chk(8'h30, 32'h9abc_ab78);
    // All-ones write sets line and control bits; the pin byte has no storage and still reads 00
    wr(8'h3c, 4'hf, 32'hffff_ffff);
    rd_chk(8'h3c, 32'h0007_00ff);
    wr(8'h3c, 4'h4, 32'h0000_0000);
    rd_chk(8'h3c, 32'h0000_00ff);
    wr(8'h34, 4'hf, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_00dc);
    wr(8'h38, 4'hf, 32'hffff_ffff);
    rd_chk(8'h38, 32'h0000_0000);
    $display("TB: register access done");
    err_chk(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    wr(8'h3c, 4'h4, 32'h0003_0000);
    err_chk(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    err_chk(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    err_chk(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    err_chk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("TB: error paths done");
    // Window 1000h..2fffh from upper zero and lower 1/2
    wr(8'h30, 4'hf, 32'h0000_0000);
    io_chk(1'b0, 32'h0000_1100, 1'b1);
    io_chk(1'b0, 32'h0000_2fff, 1'b1);
    io_chk(1'b0, 32'h0000_0fff, 1'b0);
    io_chk(1'b0, 32'h0000_3000, 1'b0);
    io_chk(1'b1, 32'h0000_1100, 1'b0);
    io_chk(1'b1, 32'h0000_3000, 1'b1);
    wr(8'h3c, 4'h4, 32'h0004_0000);
    io_chk(1'b0, 32'h0000_1100, 1'b0);
    io_chk(1'b0, 32'h0000_2fff, 1'b0);
    io_chk(1'b0, 32'h0000_1000, 1'b1);
    io_chk(1'b1, 32'h0000_1100, 1'b1);
    io_chk(1'b1, 32'h0000_1000, 1'b0);
    // Above 64KB the alias blocking no longer applies
    wr(8'h30, 4'hf, 32'h0001_0001);
    io_chk(1'b0, 32'h0001_1100, 1'b1);
    io_chk(1'b0, 32'h0000_1100, 1'b0);
    // Lower header nibble moves the top of the window up to 1ffffh
    io_limit_low = 4'hf;
    io_chk(1'b0, 32'h0001_f000, 1'b1);
    $display("TB: io decode done");
    stop_test();
  end

  // Watchdog: tests need about 80 cycles
  initial begin
    #(2000 * 10);
    error_cnt++;
    stop_test();
  end
endmodule // bcht_regs_bench
